// >>> hdl/restart_pkg.sv
package restart_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 100_000_000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUCCESS_TIME_NS = 1_000_000_000;
    localparam int SUCCESS_CYCLES = (SUCCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_LIMIT = 8'h04;
    localparam logic [7:0] OFF_WAIT = 8'h08;
    localparam logic [7:0] OFF_MON_RESTART = 8'h0C;
    localparam logic [7:0] OFF_MON_RESET = 8'h10;
    localparam logic [7:0] OFF_TICK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // Restart modes
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] MODE_ACK_ONLY = 8'h01;
    localparam logic [7:0] MODE_PF = 8'h04;
    localparam logic [7:0] MODE_FAULT = 8'h06;
    localparam logic [7:0] MODE_PF_MANUAL = 8'h0E;
    localparam logic [7:0] MODE_FAULT_MANUAL = 8'h10;
    localparam logic [7:0] MODE_ALWAYS = 8'h1A;

    // Values after reset; times in ticks of 100 ms
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h03;
    localparam logic [15:0] WAIT_RST = 16'h000A;
    localparam logic [15:0] MON_RESTART_RST = 16'h0258;
    localparam logic [15:0] MON_RESET_RST = 16'h0000;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] limit;
        logic [15:0] wait_time;
        logic [15:0] mon_restart;
        logic [15:0] mon_reset;
        logic [23:0] tick;
    } cfg_t;

    typedef struct packed {
        logic fault;
        logic power_fail;
        logic run;
        logic manual_ack;
        logic start_done;
    } drive_in_t;

    typedef struct packed {
        logic auto_ack;
        logic switch_on;
        logic exhausted;
    } drive_out_t;

    typedef enum logic [2:0] {
        S_IDLE, S_ACK_WAIT, S_DELAY, S_START, S_PROVE, S_RUN, S_EXHAUST
    } seq_state_t;

endpackage

// >>> hdl/automatic_restart_sequencer.sv
// Contract
// - Mode resets to 0; mode 0 neither acknowledges nor restarts.
// - Mode 1 acknowledges every fault, never switches the motor on.
// - Mode 4 restarts after power failure only, no further attempts.
// - Mode 6 restarts after any fault, retrying while attempts remain.
// - Mode 14 restarts after power failure only after manual acknowledge.
// - Mode 16 restarts after a fault only after manual acknowledge.
// - Mode 26 acknowledges all faults, restarts whenever run is high.
// - Attempt limit resets to 3, matters only in modes 4,6,14,16,26.
// - Attempt counter drops by one after each acknowledgement.
// - Limit n allows n+1 attempts, then restart exhausted fault.
// - Counter reloads when counter-reset time elapses after a success.
// - After exhaustion, ramp stop plus acknowledge reloads the counter.
// - Changing limit or mode by a write reloads the counter.
// - Wait time resets to 1.0 s, used only in modes 4,6,26.
// - Smaller wait time gives an earlier switch-on.
// - Switch-on is attempted only while run command is high.
// - Attempt succeeds when no fault for one second after start done.
// - Restart monitor, default 60 s, from fault; expiry gives exhausted.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module automatic_restart_sequencer #(
    parameter int TICK_DEFAULT = restart_pkg::TICK_CYCLES,
    parameter int SUCCESS_CNT = restart_pkg::SUCCESS_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Drive side
    input wire restart_pkg::drive_in_t drive_in,
    output restart_pkg::drive_out_t drive_out
);

    function automatic logic restarts(input logic [7:0] m);
        return m == restart_pkg::MODE_PF || m == restart_pkg::MODE_FAULT
            || m == restart_pkg::MODE_PF_MANUAL || m == restart_pkg::MODE_FAULT_MANUAL
            || m == restart_pkg::MODE_ALWAYS;
    endfunction

    // Bus and configuration state
    restart_pkg::cfg_t cfg_reg, cfg_next;
    logic [7:0] addr_reg, addr_next;
    logic wr_reg, wr_next;
    logic rd_reg, rd_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic hready_reg, hready_next;
    logic chg_reg, chg_next;

    // Sequencer state
    restart_pkg::seq_state_t st_reg, st_next;
    restart_pkg::drive_in_t s1_reg, s2_reg, prev_reg;
    restart_pkg::drive_out_t out_reg, out_next;
    logic [23:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic [8:0] rem_reg, rem_next;
    logic [15:0] tmr_reg, tmr_next;
    logic tmr_on_reg, tmr_on_next;
    logic [15:0] mon_reg, mon_next;
    logic mon_on_reg, mon_on_next;
    logic [23:0] prove_reg, prove_next;

    logic [31:0] status;
    logic fault_rise, pf_rise, ack_rise, fault_ev, run;
    logic pf_only, manual, wait_mode, ack_ok;
    logic try_go, try_auto, fail;

    assign status = {17'h00000, mon_on_reg, out_reg.exhausted, out_reg.switch_on,
        st_reg, rem_reg};

    // Register file and bus slave; reads take one wait state
    always_comb
    begin
        cfg_next = cfg_reg;
        addr_next = addr_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        hrdata_next = hrdata_reg;
        hready_next = 1'b1;
        chg_next = 1'b0;
        if (wr_reg)
        begin
            unique case (addr_reg)
                restart_pkg::OFF_MODE: cfg_next.mode = hwdata[7:0];
                restart_pkg::OFF_LIMIT: cfg_next.limit = hwdata[7:0];
                restart_pkg::OFF_WAIT: cfg_next.wait_time = hwdata[15:0];
                restart_pkg::OFF_MON_RESTART: cfg_next.mon_restart = hwdata[15:0];
                restart_pkg::OFF_MON_RESET: cfg_next.mon_reset = hwdata[15:0];
                restart_pkg::OFF_TICK: cfg_next.tick = hwdata[23:0];
                default: cfg_next = cfg_reg;
            endcase
            chg_next = (cfg_next.mode != cfg_reg.mode) || (cfg_next.limit != cfg_reg.limit);
        end
        if (rd_reg)
        begin
            unique case (addr_reg)
                restart_pkg::OFF_MODE: hrdata_next = {24'h000000, cfg_reg.mode};
                restart_pkg::OFF_LIMIT: hrdata_next = {24'h000000, cfg_reg.limit};
                restart_pkg::OFF_WAIT: hrdata_next = {16'h0000, cfg_reg.wait_time};
                restart_pkg::OFF_MON_RESTART: hrdata_next = {16'h0000, cfg_reg.mon_restart};
                restart_pkg::OFF_MON_RESET: hrdata_next = {16'h0000, cfg_reg.mon_reset};
                restart_pkg::OFF_TICK: hrdata_next = {8'h00, cfg_reg.tick};
                restart_pkg::OFF_STATUS: hrdata_next = status;
                default: hrdata_next = 32'h00000000;
            endcase
        end
        if (hsel && hready && htrans[1])
        begin
            addr_next = {haddr[7:2], 2'b00};
            wr_next = hwrite;
            rd_next = !hwrite;
            hready_next = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_reg <= '{restart_pkg::MODE_RST, restart_pkg::LIMIT_RST,
                restart_pkg::WAIT_RST, restart_pkg::MON_RESTART_RST,
                restart_pkg::MON_RESET_RST, 24'(TICK_DEFAULT)};
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            hrdata_reg <= 32'h00000000;
            hready_reg <= 1'b1;
            chg_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            addr_reg <= addr_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            hrdata_reg <= hrdata_next;
            hready_reg <= hready_next;
            chg_reg <= chg_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = 1'b0;

    // Drive-side decode
    always_comb
    begin
        fault_rise = s2_reg.fault && !prev_reg.fault;
        pf_rise = s2_reg.power_fail && !prev_reg.power_fail;
        ack_rise = s2_reg.manual_ack && !prev_reg.manual_ack;
        fault_ev = fault_rise || pf_rise;
        run = s2_reg.run;
        pf_only = cfg_reg.mode == restart_pkg::MODE_PF
            || cfg_reg.mode == restart_pkg::MODE_PF_MANUAL;
        manual = cfg_reg.mode == restart_pkg::MODE_PF_MANUAL
            || cfg_reg.mode == restart_pkg::MODE_FAULT_MANUAL;
        wait_mode = cfg_reg.mode == restart_pkg::MODE_PF
            || cfg_reg.mode == restart_pkg::MODE_FAULT
            || cfg_reg.mode == restart_pkg::MODE_ALWAYS;
        ack_ok = cfg_reg.mode == restart_pkg::MODE_ACK_ONLY
            || cfg_reg.mode == restart_pkg::MODE_ALWAYS
            || ((cfg_reg.mode == restart_pkg::MODE_PF
            || cfg_reg.mode == restart_pkg::MODE_FAULT) && run);
    end

    // Sequencer
    always_comb
    begin
        st_next = st_reg;
        out_next = out_reg;
        out_next.auto_ack = 1'b0;
        rem_next = rem_reg;
        tmr_next = tmr_reg;
        tmr_on_next = tmr_on_reg;
        mon_next = mon_reg;
        mon_on_next = mon_on_reg;
        prove_next = prove_reg;
        try_go = 1'b0;
        try_auto = 1'b0;
        fail = 1'b0;
        tick_next = tick_cnt_reg == 24'h000000;
        tick_cnt_next = tick_next ? cfg_reg.tick - 24'h000001 : tick_cnt_reg - 24'h000001;
        if (cfg_reg.tick == 24'h000000)
        begin
            tick_cnt_next = 24'h000000;
        end
        if (tick_reg && mon_on_reg && mon_reg != 16'h0000)
        begin
            mon_next = mon_reg - 16'h0001;
        end
        unique case (st_reg)
            restart_pkg::S_IDLE, restart_pkg::S_RUN:
            begin
                // mode 0 ignores, mode 1 only acknowledges
                if (fault_ev && cfg_reg.mode == restart_pkg::MODE_ACK_ONLY)
                begin
                    out_next.auto_ack = 1'b1;
                end
                else if (fault_ev && restarts(cfg_reg.mode) && (!pf_only || pf_rise))
                begin
                    mon_next = cfg_reg.mon_restart;
                    mon_on_next = cfg_reg.mon_restart != 16'h0000;
                    tmr_on_next = 1'b0;
                    st_next = restart_pkg::S_IDLE;
                    fail = 1'b1;
                end
                else if (st_reg == restart_pkg::S_RUN)
                begin
                    if (!run)
                    begin
                        st_next = restart_pkg::S_IDLE;
                    end
                    if (tmr_on_reg && tick_reg)
                    begin
                        tmr_next = tmr_reg - 16'h0001;
                    end
                end
            end
            restart_pkg::S_ACK_WAIT:
            begin
                if (ack_rise)
                begin
                    try_go = 1'b1;
                end
            end
            restart_pkg::S_DELAY:
            begin
                if (tmr_reg != 16'h0000)
                begin
                    if (tick_reg)
                    begin
                        tmr_next = tmr_reg - 16'h0001;
                    end
                end
                else if (run)
                begin
                    st_next = restart_pkg::S_START;
                end
            end
            restart_pkg::S_START, restart_pkg::S_PROVE:
            begin
                if (fault_ev)
                begin
                    // no further attempts in mode 4
                    st_next = restart_pkg::S_IDLE;
                    fail = cfg_reg.mode != restart_pkg::MODE_PF;
                end
                else if (!run)
                begin
                    st_next = restart_pkg::S_IDLE;
                end
                else if (st_reg == restart_pkg::S_START && s2_reg.start_done)
                begin
                    st_next = restart_pkg::S_PROVE;
                    prove_next = 24'(SUCCESS_CNT - 1);
                end
                else if (st_reg == restart_pkg::S_PROVE && prove_reg == 24'h000000)
                begin
                    st_next = restart_pkg::S_RUN;
                    mon_on_next = 1'b0;
                    tmr_next = cfg_reg.mon_reset;
                    tmr_on_next = cfg_reg.mon_reset != 16'h0000;
                end
                else if (st_reg == restart_pkg::S_PROVE)
                begin
                    prove_next = prove_reg - 24'h000001;
                end
            end
            restart_pkg::S_EXHAUST:
            begin
                if (ack_rise && !run)
                begin
                    st_next = restart_pkg::S_IDLE;
                    out_next.exhausted = 1'b0;
                    rem_next = {1'b0, cfg_reg.limit} + 9'h001;
                end
            end
        endcase
        if (fail)
        begin
            st_next = restart_pkg::S_IDLE;
            if (manual)
            begin
                st_next = restart_pkg::S_ACK_WAIT;
            end
            else if (ack_ok)
            begin
                try_go = 1'b1;
                try_auto = 1'b1;
            end
        end
        if (try_go)
        begin
            if (rem_reg == 9'h000)
            begin
                st_next = restart_pkg::S_EXHAUST;
                out_next.exhausted = 1'b1;
                mon_on_next = 1'b0;
            end
            else
            begin
                rem_next = rem_reg - 9'h001;
                out_next.auto_ack = try_auto;
                st_next = restart_pkg::S_DELAY;
                // wait only in modes 4, 6, 26
                tmr_next = wait_mode ? cfg_reg.wait_time : 16'h0000;
                tmr_on_next = 1'b0;
            end
        end
        if (mon_on_reg && mon_reg == 16'h0000 && st_reg != restart_pkg::S_EXHAUST)
        begin
            st_next = restart_pkg::S_EXHAUST;
            out_next.exhausted = 1'b1;
            mon_on_next = 1'b0;
        end
        if (st_reg == restart_pkg::S_RUN && tmr_on_reg && tmr_reg == 16'h0000)
        begin
            rem_next = {1'b0, cfg_reg.limit} + 9'h001;
            tmr_on_next = 1'b0;
        end
        if (chg_reg)
        begin
            rem_next = {1'b0, cfg_reg.limit} + 9'h001;
        end
        out_next.switch_on = st_next == restart_pkg::S_START
            || st_next == restart_pkg::S_PROVE || st_next == restart_pkg::S_RUN;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            prev_reg <= '0;
            st_reg <= restart_pkg::S_IDLE;
            out_reg <= '0;
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b0;
            rem_reg <= {1'b0, restart_pkg::LIMIT_RST} + 9'h001;
            tmr_reg <= 16'h0000;
            tmr_on_reg <= 1'b0;
            mon_reg <= 16'h0000;
            mon_on_reg <= 1'b0;
            prove_reg <= 24'h000000;
        end
        else
        begin
            s1_reg <= drive_in;
            s2_reg <= s1_reg;
            prev_reg <= s2_reg;
            st_reg <= st_next;
            out_reg <= out_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            rem_reg <= rem_next;
            tmr_reg <= tmr_next;
            tmr_on_reg <= tmr_on_next;
            mon_reg <= mon_next;
            mon_on_reg <= mon_on_next;
            prove_reg <= prove_next;
        end
    end

    assign drive_out = out_reg;

endmodule

// >>> tb/restart_props.sv
`timescale 1ns/1ps
module restart_props #(
    parameter int TICK_DEFAULT = 4,
    parameter int SUCCESS_CNT = 20
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Drive side
    input wire restart_pkg::drive_in_t drive_in,
    input wire restart_pkg::drive_out_t drive_out
);
    logic take;
    logic wr_reg;
    logic wr_next;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;

    assign take = hsel && hready && htrans[1];

    // Shadow of the mode setting, caught from bus writes
    always_comb
    begin
        wr_next = take && hwrite && haddr[7:2] == 6'h00;
        mode_next = wr_reg ? hwdata[7:0] : mode_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_reg <= 1'b0;
            mode_reg <= 8'h00;
        end
        else
        begin
            wr_reg <= wr_next;
            mode_reg <= mode_next;
        end
    end

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stretched");
    a_ack_pulse: assert property (drive_out.auto_ack |=> !drive_out.auto_ack)
        else $error("ack pulse too long");
    a_exh_motor_off: assert property (drive_out.exhausted |-> !drive_out.switch_on)
        else $error("switch-on while exhausted");
    a_run_gate: assert property ((!drive_in.run) [*6] |-> !drive_out.switch_on)
        else $error("switch-on without run");
    a_mode0_quiet: assert property ((mode_reg == restart_pkg::MODE_OFF) [*4]
        |-> !drive_out.auto_ack && !drive_out.switch_on)
        else $error("activity in mode off");
    a_mode1_no_start: assert property ((mode_reg == restart_pkg::MODE_ACK_ONLY) [*4]
        ##0 !drive_out.switch_on |=> !drive_out.switch_on)
        else $error("switch-on in ack-only mode");
    a_manual_no_ack: assert property ((mode_reg == restart_pkg::MODE_PF_MANUAL
        || mode_reg == restart_pkg::MODE_FAULT_MANUAL) [*4] |-> !drive_out.auto_ack)
        else $error("auto ack in manual mode");
    a_exh_sticky: assert property ((drive_out.exhausted && !drive_in.manual_ack) [*5]
        |=> drive_out.exhausted)
        else $error("exhausted cleared without ack");

    c_ack: cover property (drive_out.auto_ack);
    c_on: cover property ($rose(drive_out.switch_on));
    c_exh: cover property ($rose(drive_out.exhausted));
endmodule

bind automatic_restart_sequencer restart_props #(
    .TICK_DEFAULT(TICK_DEFAULT),
    .SUCCESS_CNT(SUCCESS_CNT)
) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .drive_in(drive_in), .drive_out(drive_out)
);

// >>> tb/drive_model.sv
`timescale 1ns/1ps
module drive_model (
    // Clock
    input wire logic hclk,
    // Bench commands: fault, power fail, run, manual ack
    input wire logic [3:0] ev,
    input wire logic [7:0] done_dly,
    // Sequencer side
    input wire restart_pkg::drive_out_t drive_out,
    output restart_pkg::drive_in_t drive_in
);
    logic [7:0] on_cnt;

    always_ff @(posedge hclk)
    begin
        if (drive_out.switch_on !== 1'b1)
            on_cnt <= 8'h00;
        else if (on_cnt != 8'hFF)
            on_cnt <= on_cnt + 8'h01;
    end

    always_comb
    begin
        drive_in.fault = ev[3];
        drive_in.power_fail = ev[2];
        drive_in.run = ev[1];
        drive_in.manual_ack = ev[0];
        drive_in.start_done = drive_out.switch_on === 1'b1 && on_cnt >= done_dly;
    end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int TICK = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] ev = 4'h0;
    logic [7:0] done_dly = 8'h05;
    logic on_q = 1'b0;
    logic [31:0] rd;
    restart_pkg::drive_in_t drive_in;
    restart_pkg::drive_out_t drive_out;
    int err_count = 0;
    int total_checks = 0;
    int seed = 45517;
    int acks = 0;
    int ons = 0;
    int a0, o0, da, n, wt;
    logic [7:0] md [8] = '{8'h00, 8'h01, 8'h04, 8'h04, 8'h06, 8'h1A, 8'h0E, 8'h10};
    logic [7:0] eb [8] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03, 8'h02, 8'h03};
    logic [7:0] ea [8] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0] eo [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};

    always #50 hclk = ~hclk;

    always @(posedge hclk)
    begin
        on_q <= drive_out.switch_on;
        if (drive_out.auto_ack === 1'b1)
            acks <= acks + 1;
        if (drive_out.switch_on === 1'b1 && on_q === 1'b0)
            ons <= ons + 1;
    end

    automatic_restart_sequencer #(.TICK_DEFAULT(TICK), .SUCCESS_CNT(20)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .drive_in(drive_in), .drive_out(drive_out));
    drive_model model (.hclk(hclk), .ev(ev), .done_dly(done_dly), .drive_out(drive_out),
        .drive_in(drive_in));

    function automatic logic [31:0] dflt(input int i);
        case (i)
            0: return 32'(restart_pkg::MODE_RST);
            1: return 32'(restart_pkg::LIMIT_RST);
            2: return 32'(restart_pkg::WAIT_RST);
            3: return 32'(restart_pkg::MON_RESTART_RST);
            4: return 32'(restart_pkg::MON_RESET_RST);
            5: return 32'(TICK);
            6: return 32'(restart_pkg::LIMIT_RST) + 32'h1;
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves just after one
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        repeat (4) @(posedge hclk);
        ev[k] <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic wait_on(input int b, input logic v, input int lim);
        wt = 0;
        while (drive_out[b] !== v && wt < lim)
        begin
            @(posedge hclk);
            wt++;
        end
        chk(32'(drive_out[b]), 32'(v));
    endtask

    // Ramp stop, then a new mode with run high
    task automatic set_mode(input logic [7:0] m);
        ev[1] <= 1'b0;
        repeat (8) @(posedge hclk);
        bus(1'b1, restart_pkg::OFF_MODE, 32'(m));
        ev[1] <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(100 * 20000);
        err_count++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(rd, dflt(i));
        end
        $display("defaults done");
        bus(1'b1, restart_pkg::OFF_MON_RESTART, 32'h0);
        bus(1'b1, restart_pkg::OFF_WAIT, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            done_dly <= 8'(2 + {$random(seed)} % 8);
            set_mode(md[i]);
            a0 = acks;
            o0 = ons;
            pulse(int'(eb[i]));
            repeat (60) @(posedge hclk);
            chk(32'(acks - a0), 32'(ea[i]));
            if (i >= 6)
            begin
                chk(32'(ons - o0), 32'h0);
                pulse(0);
                repeat (60) @(posedge hclk);
            end
            chk(32'(ons - o0), 32'(eo[i]));
            if (eo[i] == 8'h01)
            begin
                bus(1'b0, restart_pkg::OFF_STATUS, 32'h0);
                chk(32'(rd[11:0]), 32'h0A03);
            end
            $display("mode %0d done", md[i]);
        end
        set_mode(restart_pkg::MODE_FAULT);
        for (int w = 0; w < 2; w++)
        begin
            ev[1] <= 1'b0;
            bus(1'b1, restart_pkg::OFF_WAIT, 32'h1 + 32'(w * 4));
            ev[1] <= 1'b1;
            @(posedge hclk);
            pulse(3);
            wait_on(1, 1'b1, 200);
            if (w == 0)
                da = wt;
        end
        chk(32'(wt - da >= 12 && wt - da <= 20), 32'h1);
        bus(1'b1, restart_pkg::OFF_WAIT, 32'h2);
        $display("wait time done");
        n = {$random(seed)} % 3;
        bus(1'b1, restart_pkg::OFF_LIMIT, 32'(n));
        bus(1'b0, restart_pkg::OFF_STATUS, 32'h0);
        chk(32'(rd[8:0]), 32'(n + 1));
        done_dly <= 8'hFF;
        o0 = ons;
        pulse(3);
        repeat (n + 1)
        begin
            wait_on(1, 1'b1, 200);
            pulse(3);
        end
        wait_on(0, 1'b1, 100);
        chk(32'(ons - o0), 32'(n + 1));
        ev[1] <= 1'b0;
        repeat (8) @(posedge hclk);
        pulse(0);
        wait_on(0, 1'b0, 20);
        bus(1'b0, restart_pkg::OFF_STATUS, 32'h0);
        chk(32'(rd[8:0]), 32'(n + 1));
        done_dly <= 8'h05;
        $display("exhaustion done");
        bus(1'b1, restart_pkg::OFF_LIMIT, 32'h3);
        bus(1'b1, restart_pkg::OFF_MON_RESET, 32'h2);
        ev[1] <= 1'b1;
        pulse(3);
        repeat (80) @(posedge hclk);
        bus(1'b0, restart_pkg::OFF_STATUS, 32'h0);
        chk(32'(rd[8:0]), 32'h4);
        $display("counter reload done");
        bus(1'b1, restart_pkg::OFF_MON_RESTART, 32'h5);
        set_mode(restart_pkg::MODE_ALWAYS);
        ev[1] <= 1'b0;
        pulse(3);
        wait_on(0, 1'b1, 200);
        pulse(0);
        wait_on(0, 1'b0, 20);
        $display("restart monitor done");
        end_of_test();
    end
endmodule
